// ### design/aux_cfg_pkg.sv
// constants shared by the auxiliary run-time configuration register bank
`default_nettype none
package aux_cfg_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_OFF_DELAY  = 8'hB8;
   localparam logic [7:0] IDX_IRQ_ROUTE  = 8'hC0;
   localparam logic [7:0] IDX_FORCED_CHG = 8'hC1;
   localparam logic [7:0] IDX_FDC_RATE   = 8'hC2;
   localparam logic [7:0] IDX_UART1_FIFO = 8'hC3;
   localparam logic [7:0] IDX_UART2_FIFO = 8'hC4;
   localparam int         ADDR_W         = 10;
   localparam int         IDX_LSB        = 2;

   // reset values
   localparam logic [7:0] RST_OFF_DELAY  = 8'h00;
   localparam logic [7:0] RST_IRQ_ROUTE  = 8'h00;
   localparam logic [1:0] RST_FORCED_CHG = 2'h3;
   localparam logic [7:0] RST_SHADOW     = 8'h00;

   // field layout
   localparam int         DLY_W          = 6;
   localparam int         RT_PARALLEL    = 0;
   localparam int         RT_SCI_PIN     = 2;
   localparam int         RT_SCI_HIGH    = 3;
   localparam int         RT_SCI_OD      = 4;
   localparam int         RT_SHARE_LO    = 5;
   localparam int         RT_SHARE_HI    = 6;
   localparam int         RT_SMI_PIN     = 7;
   localparam logic [7:0] RT_WR_MASK     = 8'hFD;
   localparam logic [7:0] FDC_RATE_MASK  = 8'hDF;
   localparam logic [7:0] FIFO_MASK      = 8'hCF;
   localparam logic [1:0] SHARE_PME      = 2'h0;
   localparam logic [1:0] SHARE_SCI      = 2'h1;
   localparam logic [1:0] SHARE_IRQ9     = 2'h2;

   // timing: one delay step is half a second
   localparam int         STEP_MS        = 500;
   localparam int         CLK_PERIOD_NS  = 20;
   localparam int         STEP_CYC       = STEP_MS * 1000000 / CLK_PERIOD_NS;

   typedef enum logic [0:0] {
      T_IDLE = 1'b0,
      T_RUN  = 1'b1
   } timer_state_t;
endpackage : aux_cfg_pkg
`default_nettype wire

// ### design/aux_cfg_regs.sv
// auxiliary run-time configuration registers behind an APB slave
// Functional notes
// - off delay is (six-bit code plus one) half-second steps.
// - each delay lasts its nominal time, at most 10 ms longer.
// - delay starts on button press with off enable and delay option set.
// - delay field resets to code zero, half a second.
// - routing bit 0 selects serial stream or parallel IRQ pins.
// - parallel mode disables boot ROM buffer, pins become IRQ15/IRQ14.
// - serial/parallel choice does not move SCI or SMI.
// - bit 2 puts SCI in serial frame or on dedicated pin.
// - bit 3 sets SCI polarity, low or high active.
// - bit 4 sets SCI driver, push-pull or open drain.
// - shared pin field picks PME, SCI, IRQ9; code 11 reserved.
// - shared field low bit set overrides the programmed SCI IRQ number.
// - shared pin: PME low open drain, SCI per bits, IRQ9 high push-pull.
// - bit 7 sends SMI in serial IRQ2 slot or on dedicated pin.
// - dedicated SMI pin polarity and driver come from GPIO setup.
// - forced change bits set by software, never cleared by it.
// - hardware clears a forced bit on step with that drive selected.
// - disk change status is per-drive forced bit or change input.
// - forced change register upper bits read zero.
// - floppy rate shadow layout: reset, power down, write_precompensation, rate.
// - uart one shadow: trigger, dma, tx reset, rx reset, enable.
// - uart two shadow uses the same layout.
//
// Our own choice: the APB register port.
`default_nettype none
module aux_cfg_regs
   import aux_cfg_pkg::*;
#(
   parameter int STEP_CYCLES = STEP_CYC
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              power_button_pin,
   input  wire logic              off_enable,
   input  wire logic              power_off_delay_option,
   output logic                   power_off_expired,
   output logic                   power_off_running,
   input  wire logic              sci_event,
   input  wire logic              smi_event,
   input  wire logic              pme_event,
   input  wire logic              irq9_event,
   input  wire logic              irq14_event,
   input  wire logic              irq15_event,
   input  wire logic              smi_pin_active_high,
   input  wire logic              smi_pin_push_pull,
   output logic                   parallel_irq_mode,
   output logic                   boot_rom_buffer_enable,
   output logic                   serial_interrupt_pin_out,
   output logic                   serial_interrupt_pin_oe_n,
   output logic                   bus_clock_pin_irq_out,
   output logic                   bus_clock_pin_irq_oe_n,
   output logic                   sci_frame_request,
   output logic                   smi_frame_request,
   output logic                   sci_dedicated_out,
   output logic                   sci_dedicated_oe_n,
   output logic                   sys_mgmt_irq_pin_out,
   output logic                   sys_mgmt_irq_pin_oe_n,
   output logic                   power_mgmt_event_pin_out,
   output logic                   power_mgmt_event_pin_oe_n,
   output logic                   sci_irq_select_ignore,
   input  wire logic              head_step_signal_n,
   input  wire logic              drive_zero_select_n,
   input  wire logic              drive_one_select_n,
   input  wire logic              disk_change_input_n,
   output logic                   disk_change_status_bit,
   input  wire logic              fdc_rate_write,
   input  wire logic              uart_one_fifo_write,
   input  wire logic              uart_two_fifo_write,
   input  wire logic [7:0]        control_write_data
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [4:0] meta_q;
   logic [4:0] sync_q;
   logic       button_prev_q;

   // raw pins: first stage is read only by the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 5'h1F;
         sync_q <= 5'h1F;
      end else begin
         meta_q <= {disk_change_input_n, drive_one_select_n,
                    drive_zero_select_n, head_step_signal_n,
                    ~power_button_pin};
         sync_q <= meta_q;
      end
   end

   logic button_s;
   logic step_s;
   logic ds0_s;
   logic ds1_s;
   logic dskchg_s;
   assign button_s = ~sync_q[0];
   assign step_s   = ~sync_q[1];
   assign ds0_s    = ~sync_q[2];
   assign ds1_s    = ~sync_q[3];
   assign dskchg_s = ~sync_q[4];

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   logic [7:0]     off_delay_q;
   logic [7:0]     route_q;
   logic [1:0]     forced_q;
   logic [7:0]     fdc_rate_q;
   logic [7:0]     uart1_q;
   logic [7:0]     uart2_q;
   logic [7:0]     idx;
   logic           wr_en;
   logic [7:0]     rd_byte;
   logic           mapped;

   assign idx   = paddr[IDX_LSB +: 8];
   assign wr_en = psel & penable & pready & pwrite;

   // read mux; reserved bits read zero
   always_comb begin
      rd_byte = 8'h00;
      mapped  = 1'b1;
      case (idx)
         IDX_OFF_DELAY:  rd_byte = off_delay_q;
         IDX_IRQ_ROUTE:  rd_byte = route_q;
         IDX_FORCED_CHG: rd_byte = {6'h00, forced_q};
         IDX_FDC_RATE:   rd_byte = fdc_rate_q;
         IDX_UART1_FIFO: rd_byte = uart1_q;
         IDX_UART2_FIFO: rd_byte = uart2_q;
         default:        mapped  = 1'b0;
      endcase
   end

   // answer one cycle after setup: no wait states beyond that
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_delay_q <= RST_OFF_DELAY;
      end else if (wr_en && idx == IDX_OFF_DELAY) begin
         off_delay_q <= {2'h0, pwdata[DLY_W-1:0]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         route_q <= RST_IRQ_ROUTE;
      end else if (wr_en && idx == IDX_IRQ_ROUTE) begin
         route_q <= pwdata[7:0] & RT_WR_MASK;
      end
   end

   // forced change: software sets, step with drive select clears;
   // a set in the same cycle as a clear wins
   logic [1:0] fc_set;
   logic [1:0] fc_clr;
   assign fc_set = (wr_en && idx == IDX_FORCED_CHG) ? pwdata[1:0] : 2'h0;
   assign fc_clr = {step_s & ds1_s, step_s & ds0_s};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         forced_q <= RST_FORCED_CHG;
      end else begin
         forced_q <= fc_set | (forced_q & ~fc_clr);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disk_change_status_bit <= 1'b0;
      end else begin
         disk_change_status_bit <= (ds0_s & forced_q[0])
                                 | (ds1_s & forced_q[1])
                                 | dskchg_s;
      end
   end

   // shadows follow the control-register write strobes only;
   // APB writes to these indices fall through untouched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fdc_rate_q <= RST_SHADOW;
         uart1_q    <= RST_SHADOW;
         uart2_q    <= RST_SHADOW;
      end else begin
         if (fdc_rate_write) begin
            fdc_rate_q <= control_write_data & FDC_RATE_MASK;
         end
         if (uart_one_fifo_write) begin
            uart1_q <= control_write_data & FIFO_MASK;
         end
         if (uart_two_fifo_write) begin
            uart2_q <= control_write_data & FIFO_MASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // soft power off delay
   // ----------------------------------------------------------------
   timer_state_t     tstate_q;
   logic [31:0]      tick_q;
   logic [DLY_W-1:0] steps_q;
   logic             start;
   logic             tick_wrap;

   assign start     = off_enable & power_off_delay_option
                    & button_s & ~button_prev_q;
   assign tick_wrap = (tick_q == 32'(STEP_CYCLES - 1));

   // total = (code + 1) steps, exact, well inside the 10 ms slack;
   // a press while running is ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tstate_q          <= T_IDLE;
         tick_q            <= 32'h0000_0000;
         steps_q           <= '0;
         button_prev_q     <= 1'b0;
         power_off_expired <= 1'b0;
      end else begin
         button_prev_q     <= button_s;
         power_off_expired <= 1'b0;
         case (tstate_q)
            T_IDLE: begin
               if (start) begin
                  tstate_q <= T_RUN;
                  tick_q   <= 32'h0000_0000;
                  steps_q  <= off_delay_q[DLY_W-1:0];
               end
            end
            T_RUN: begin
               tick_q <= tick_wrap ? 32'h0000_0000 : tick_q + 32'h1;
               if (tick_wrap) begin
                  if (steps_q == '0) begin
                     tstate_q          <= T_IDLE;
                     power_off_expired <= 1'b1;
                  end else begin
                     steps_q <= steps_q - 1'b1;
                  end
               end
            end
            default: tstate_q <= T_IDLE;
         endcase
      end
   end

   assign power_off_running = (tstate_q == T_RUN);

   // ----------------------------------------------------------------
   // interrupt routing to pins and serial frame requests
   // ----------------------------------------------------------------
   logic       par;
   logic       sci_pin_sel;
   logic       sci_lvl;
   logic       sci_od;
   logic [1:0] share;

   assign par         = route_q[RT_PARALLEL];
   assign sci_pin_sel = route_q[RT_SCI_PIN];
   assign sci_od      = route_q[RT_SCI_OD];
   assign share       = route_q[RT_SHARE_HI:RT_SHARE_LO];
   assign sci_lvl     = route_q[RT_SCI_HIGH] ? sci_event : ~sci_event;

   // open drain only drives low, on assert if low active, while idle if high active; push-pull drives always
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         parallel_irq_mode         <= 1'b0;
         boot_rom_buffer_enable    <= 1'b1;
         serial_interrupt_pin_out  <= 1'b0;
         serial_interrupt_pin_oe_n <= 1'b1;
         bus_clock_pin_irq_out     <= 1'b0;
         bus_clock_pin_irq_oe_n    <= 1'b1;
         sci_frame_request         <= 1'b0;
         smi_frame_request         <= 1'b0;
         sci_dedicated_out         <= 1'b0;
         sci_dedicated_oe_n        <= 1'b1;
         sys_mgmt_irq_pin_out      <= 1'b0;
         sys_mgmt_irq_pin_oe_n     <= 1'b1;
         sci_irq_select_ignore     <= 1'b0;
      end else begin
         parallel_irq_mode         <= par;
         boot_rom_buffer_enable    <= ~par;
         serial_interrupt_pin_out  <= irq15_event;
         serial_interrupt_pin_oe_n <= ~par;
         bus_clock_pin_irq_out     <= irq14_event;
         bus_clock_pin_irq_oe_n    <= ~par;
         // frame requests ignore the parallel bit
         sci_frame_request     <= ~sci_pin_sel & sci_event;
         smi_frame_request     <= ~route_q[RT_SMI_PIN] & smi_event;
         sci_dedicated_out     <= sci_od ? 1'b0 : sci_lvl;
         sci_dedicated_oe_n    <= ~sci_pin_sel | (sci_od & sci_lvl);
         sys_mgmt_irq_pin_out  <= smi_pin_push_pull
                                  ? ~(smi_event ^ smi_pin_active_high)
                                  : 1'b0;
         sys_mgmt_irq_pin_oe_n <= ~route_q[RT_SMI_PIN]
                                  | (~smi_pin_push_pull
                                     & ~(smi_event ^ smi_pin_active_high));
         sci_irq_select_ignore <= share[0];
      end
   end

   // shared pin; reserved code leaves the pin undriven
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_mgmt_event_pin_out  <= 1'b0;
         power_mgmt_event_pin_oe_n <= 1'b1;
      end else begin
         case (share)
            SHARE_PME: begin
               power_mgmt_event_pin_out  <= 1'b0;
               power_mgmt_event_pin_oe_n <= ~pme_event;
            end
            SHARE_SCI: begin
               power_mgmt_event_pin_out  <= sci_od ? 1'b0 : sci_lvl;
               power_mgmt_event_pin_oe_n <= sci_od & sci_lvl;
            end
            SHARE_IRQ9: begin
               power_mgmt_event_pin_out  <= irq9_event;
               power_mgmt_event_pin_oe_n <= 1'b0;
            end
            default: begin
               power_mgmt_event_pin_out  <= 1'b0;
               power_mgmt_event_pin_oe_n <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   forced_clear_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (fc_clr[0] && !fc_set[0]) |=> !forced_q[0])
      else $error("forced change 0 not cleared by step");

   forced_sticky_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (forced_q[1] && !fc_clr[1]) |=> forced_q[1])
      else $error("forced change 1 dropped without step");

   disk_status_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (dskchg_s && $stable(dskchg_s)) |=> disk_change_status_bit)
      else $error("disk change status missed input");

   shadow_ignore_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr_en && idx == IDX_FDC_RATE && !fdc_rate_write)
      |=> $stable(fdc_rate_q))
      else $error("shadow changed by bus write");

   shadow_capture_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      uart_one_fifo_write
      |=> uart1_q == ($past(control_write_data) & FIFO_MASK))
      else $error("uart one shadow not captured");

   parallel_pins_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      par |=> (!boot_rom_buffer_enable && !serial_interrupt_pin_oe_n))
      else $error("parallel mode pins not enabled");

   smi_route_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (route_q[RT_SMI_PIN] && smi_event) |=> !smi_frame_request)
      else $error("smi sent in frame while on pin");

   shared_irq9_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (share == SHARE_IRQ9) |=> !power_mgmt_event_pin_oe_n)
      else $error("irq9 shared pin not driven");

   timer_start_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (start && tstate_q == T_IDLE) |=> power_off_running ##1
      power_off_running)
      else $error("off delay did not start");

   apb_answer_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (psel && !penable) |=> pready)
      else $error("apb access not answered");

endmodule : aux_cfg_regs
`default_nettype wire

// ### tb/drive_side_model.sv
// floppy drive cable model driving the block's active-low drive pins
`default_nettype none
module drive_side_model (
   input  wire logic step,
   input  wire logic sel0,
   input  wire logic sel1,
   input  wire logic chg,
   output logic      head_step_signal_n,
   output logic      drive_zero_select_n,
   output logic      drive_one_select_n,
   output logic      disk_change_input_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // cable levels
   // ----------------------------------------
   // the drive pins are asserted low; the bench speaks active high
   assign head_step_signal_n  = ~step;
   assign drive_zero_select_n = ~sel0;
   assign drive_one_select_n  = ~sel1;
   assign disk_change_input_n = ~chg;
endmodule : drive_side_model
`default_nettype wire

// ### tb/aux_cfg_regs_tb.sv
// self-checking bench for the auxiliary configuration register bank
`default_nettype none
module aux_cfg_regs_tb
   import aux_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int S = 20;  // short delay step keeps the run brief
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic              pclk = 0, presetn = 0, psel = 0, penable = 0;
   logic              pwrite = 0, pready, pslverr;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0, prdata;
   logic              power_button_pin = 0, off_enable = 0;
   logic              power_off_delay_option = 0;
   logic              power_off_expired, power_off_running;
   logic              sci_event = 1, smi_event = 1, pme_event = 1;
   logic              irq9_event = 1, irq14_event = 0, irq15_event = 1;
   logic              smi_pin_active_high = 0, smi_pin_push_pull = 0;
   logic              parallel_irq_mode, boot_rom_buffer_enable;
   logic              serial_interrupt_pin_out, serial_interrupt_pin_oe_n;
   logic              bus_clock_pin_irq_out, bus_clock_pin_irq_oe_n;
   logic              sci_frame_request, smi_frame_request;
   logic              sci_dedicated_out, sci_dedicated_oe_n;
   logic              sys_mgmt_irq_pin_out, sys_mgmt_irq_pin_oe_n;
   logic              power_mgmt_event_pin_out, power_mgmt_event_pin_oe_n;
   logic              sci_irq_select_ignore, disk_change_status_bit;
   logic              head_step_signal_n, drive_zero_select_n;
   logic              drive_one_select_n, disk_change_input_n;
   logic              step = 0, sel0 = 0, sel1 = 0, chg = 0;
   logic              fdc_rate_write = 0, uart_one_fifo_write = 0;
   logic              uart_two_fifo_write = 0;
   logic [7:0]        control_write_data = '0;
   int                n_fail = 0, check_count = 0;

   aux_cfg_regs #(.STEP_CYCLES(S)) u_dut (.*);
   drive_side_model u_drive (.*);

   // free-running 50 MHz clock
   always #10 pclk = ~pclk;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick

   task automatic fail(input string m);
      n_fail++;
      $display("BAD %0t %s", $time, m);
   endtask : fail

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      check_count++;
      if (got !== exp) fail(m);
   endtask : chk

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, output logic [31:0] rd,
                      output logic er);
      @(posedge pclk);
      psel    <= 1;
      penable <= 0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1;
      // only the watchdog ends a wait for ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 0;
      penable <= 0;
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1, idx, d, rd, er);
   endtask : wr

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
                         input logic e);
      logic [31:0] rd;
      logic        er;
      apb(0, idx, 8'h00, rd, er);
      chk(rd, {24'h0, exp}, "read data");
      chk({31'h0, er}, {31'h0, e}, "slave error");
   endtask : rd_chk

   // resolved level of a pin; x when its enable is unknown
   function automatic logic pin(input logic o, input logic oe_n);
      return oe_n === 1'b1 ? 1'bz : (oe_n === 1'b0 ? o : 1'bx);
   endfunction : pin
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      rd_chk(IDX_OFF_DELAY, 8'h00, 0);
      rd_chk(IDX_IRQ_ROUTE, 8'h00, 0);
      rd_chk(IDX_FORCED_CHG, 8'h03, 0);
      rd_chk(IDX_FDC_RATE, 8'h00, 0);
      rd_chk(8'h00, 8'h00, 1);           // unmapped index
      chk({31'h0, boot_rom_buffer_enable}, 1, "boot buffer");
      $display("t_reset done");
   endtask : t_reset

   task automatic t_delay;
      logic [5:0] c [2] = '{6'h00, 6'h3F};
      int         n, lo;
      wr(IDX_OFF_DELAY, 8'hFF);
      rd_chk(IDX_OFF_DELAY, 8'h3F, 0);
      off_enable <= 1;
      // press without the delay option must not start the timer
      power_button_pin <= 1;
      tick(8);
      chk({31'h0, power_off_running}, 0, "ran w/o option");
      power_button_pin <= 0;
      for (int i = 0; i < 2; i++) begin
         wr(IDX_OFF_DELAY, {2'b00, c[i]});
         power_off_delay_option <= 1;
         tick(4);
         power_button_pin <= 1;
         n = 0;
         lo = (c[i] + 1) * S;
         do begin
            @(posedge pclk);
            n++;
            if (n == 8) chk({31'h0, power_off_running}, 1, "idle");
         end while (power_off_expired !== 1'b1 && n < 2000);
         power_button_pin <= 0;
         chk({31'h0, n >= lo && n <= lo + 6}, 1, "delay length");
      end
      $display("t_delay done");
   endtask : t_delay

   task automatic t_route;
      logic [7:0] rv [9] = '{8'h02, 8'h01, 8'h0C, 8'h04, 8'h14,
                             8'h80, 8'h40, 8'h60, 8'h2C};
      logic       sv [9] = '{1, 1, 1, 1, 0, 1, 1, 1, 1};
      logic [9:0] ev [9] = '{10'b01zz11zz00, 10'b101011zz00,
                             10'b01zz011z00, 10'b01zz010z00,
                             10'b01zz01zz00, 10'b01zz10z000,
                             10'b01zz11zz10, 10'b01zz11zzz1,
                             10'b01zz011z11};
      logic [9:0] v;
      for (int i = 0; i < 9; i++) begin
         sci_event <= sv[i];
         wr(IDX_IRQ_ROUTE, rv[i]);
         rd_chk(IDX_IRQ_ROUTE, rv[i] & 8'hFD, 0);
         v = {parallel_irq_mode, boot_rom_buffer_enable,
              pin(serial_interrupt_pin_out, serial_interrupt_pin_oe_n),
              pin(bus_clock_pin_irq_out, bus_clock_pin_irq_oe_n),
              sci_frame_request, smi_frame_request,
              pin(sci_dedicated_out, sci_dedicated_oe_n),
              pin(sys_mgmt_irq_pin_out, sys_mgmt_irq_pin_oe_n),
              pin(power_mgmt_event_pin_out, power_mgmt_event_pin_oe_n),
              sci_irq_select_ignore};
         chk({22'h0, v}, {22'h0, ev[i]}, "routing");
      end
      // active-high open drain pulls low while idle, push-pull drives
      smi_pin_active_high <= 1;
      smi_event           <= 0;
      wr(IDX_IRQ_ROUTE, 8'h80);
      tick(2);
      chk({31'h0, pin(sys_mgmt_irq_pin_out, sys_mgmt_irq_pin_oe_n)}, 0,
          "smi open drain");
      smi_pin_push_pull <= 1;
      smi_event         <= 1;
      tick(2);
      chk({31'h0, pin(sys_mgmt_irq_pin_out, sys_mgmt_irq_pin_oe_n)}, 1,
          "smi push pull");
      $display("t_route done");
   endtask : t_route

   task automatic pulse_step;
      step <= 1;
      tick(5);
      step <= 0;
      tick(5);
   endtask : pulse_step

   task automatic t_forced;
      sel0 <= 1;
      tick(5);
      chk({31'h0, disk_change_status_bit}, 1, "fc0 status");
      wr(IDX_FORCED_CHG, 8'h00);
      rd_chk(IDX_FORCED_CHG, 8'h03, 0);
      pulse_step;
      rd_chk(IDX_FORCED_CHG, 8'h02, 0);
      chk({31'h0, disk_change_status_bit}, 0, "fc0 cleared");
      sel0 <= 0;
      sel1 <= 1;
      tick(5);
      chk({31'h0, disk_change_status_bit}, 1, "fc1 status");
      pulse_step;
      rd_chk(IDX_FORCED_CHG, 8'h00, 0);
      wr(IDX_FORCED_CHG, 8'hFF);
      rd_chk(IDX_FORCED_CHG, 8'h03, 0);
      sel1 <= 0;
      tick(5);
      chk({31'h0, disk_change_status_bit}, 0, "no drive");
      chg <= 1;
      tick(5);
      chk({31'h0, disk_change_status_bit}, 1, "change pin");
      chg <= 0;
      $display("t_forced done");
   endtask : t_forced

   task automatic strobe(input int i, input logic [7:0] d);
      @(posedge pclk);
      control_write_data  <= d;
      fdc_rate_write      <= (i == 0);
      uart_one_fifo_write <= (i == 1);
      uart_two_fifo_write <= (i == 2);
      @(posedge pclk);
      fdc_rate_write      <= 0;
      uart_one_fifo_write <= 0;
      uart_two_fifo_write <= 0;
   endtask : strobe

   task automatic t_shadow;
      logic [7:0] ix [3] = '{IDX_FDC_RATE, IDX_UART1_FIFO, IDX_UART2_FIFO};
      logic [7:0] mk [3] = '{8'hDF, 8'hCF, 8'hCF};
      for (int i = 0; i < 3; i++) begin
         strobe(i, 8'hFF);
         rd_chk(ix[i], mk[i], 0);
         strobe(i, 8'h41);
         wr(ix[i], 8'hFF);
         rd_chk(ix[i], 8'h41, 0);
      end
      $display("t_shadow done");
   endtask : t_shadow

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   // ----------------------------------------
   // sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      t_reset;
      t_delay;
      t_route;
      t_forced;
      t_shadow;
      summarize;
   end

   // the tests need under 5000 cycles; four times that means a hang
   initial begin
      repeat (20000) @(posedge pclk);
      fail("timeout");
      summarize;
   end
endmodule : aux_cfg_regs_tb
`default_nettype wire
